// ===== logic/wdw_cfg.svh
`ifndef WDW_CFG_SVH
`define WDW_CFG_SVH

// register addresses on the plain port
`define WDW_ADDR_CONTROL     4'h0
`define WDW_ADDR_RESET_CAUSE 4'h1
`define WDW_ADDR_STATUS      4'h2
`define WDW_ADDR_WAKE_EN     4'h3

// watchdog control layout and power-on value
`define WDW_KEY_MSB          7
`define WDW_KEY_LSB          3
`define WDW_SEL_MSB          2
`define WDW_SEL_LSB          0
`define WDW_CONTROL_RESET    8'h53
`define WDW_KEY_A            5'h0a
`define WDW_KEY_B            5'h15

// reset cause and status bit positions
`define WDW_KEY_FLAG_BIT     0
`define WDW_PDF_BIT          0
`define WDW_TO_BIT           1

// oscillator and software reset delay
`define WDW_OSC_HZ           32000
`define WDW_SRESET_DELAY_NS  32'd16000
`define WDW_CLK_PERIOD_NS    32'd8
`define WDW_SRESET_CYCLES    ((`WDW_SRESET_DELAY_NS + `WDW_CLK_PERIOD_NS - 32'd1) / `WDW_CLK_PERIOD_NS)

`endif

// ===== logic/wdw_pkg.sv
package wdw_pkg;
  typedef enum logic [1:0] {
    WDW_RUN,
    WDW_HALTED,
    WDW_KEY_WAIT
  } wdw_state_type;
endpackage

// ===== logic/wdw_watchdog_wakeup.sv
// Notes on behaviour
// [R1] halted core wakes on pin, interrupt, overflow
// [R2] halt enters low power, sets power-down flag
// [R3] power-down flag cleared by power-up, clear instruction
// [R4] per-pin wake enable, falling edge wakes
// [R5] disabled or stack-full interrupt resumes after halt
// [R6] enabled interrupt with free stack is serviced
// [R7] request already pending at halt cannot wake
// [R8] counter ticks on low-speed oscillator
// [R9] select codes 0-6 give 2^8..2^17 periods
// [R10] select code 7 gives 2^18 period
// [R11] bad key resets device after delay
// [R12] key powers up as enabling value
// [R13] key reset sets sticky flag, software clears
// [R14] running overflow resets device, sets timeout
// [R15] halted overflow sets flags, resets counter, stack
// [R16] bad key, clear, halt clear the counter
// [R17] software clears watchdog before period elapses
// [R18] power-on reset starts execution at zero
// [R19] halt clears counter, counting continues
//
// Decided for this implementation: the address map and strobed register access.
`include "wdw_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module wdw_watchdog_wakeup
  import wdw_pkg::*;
#(
  parameter int PORT_WIDTH = 8,
  parameter int SRESET_CYCLES = `WDW_SRESET_CYCLES
) (
  // clock and power-on reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // low-speed oscillator tick, one cycle per oscillator period
  input  wire logic                  low_speed_internal_osc,
  // core events
  input  wire logic                  halt_exec,
  input  wire logic                  watchdog_clear_instruction,
  input  wire logic                  irq_request,
  input  wire logic                  irq_enabled,
  input  wire logic                  stack_full,
  input  wire logic [PORT_WIDTH-1:0] port_a_in,
  // register port
  input  wire logic [3:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [7:0]            reg_rdata,
  // results to the core
  output logic                       halted,
  output logic                       wake,
  output logic                       wake_take_irq,
  output logic                       device_reset,
  output logic                       pc_sp_reset
);

  // the read-back byte holds at most eight wake enables
  if (PORT_WIDTH < 1 || PORT_WIDTH > 8) begin : g_bad_width
    $error("PORT_WIDTH must be 1..8");
  end
  if (SRESET_CYCLES < 1) begin : g_bad_delay
    $error("SRESET_CYCLES must be at least 1");
  end

  localparam int DLY_W = $clog2(SRESET_CYCLES + 1);

  wdw_state_type             state_q, state_d;
  logic [7:0]                control_q, control_d;
  logic [PORT_WIDTH-1:0]     wake_en_q, wake_en_d;
  logic [PORT_WIDTH-1:0]     pins_q, pins_d;
  logic                      pdf_q, pdf_d;
  logic                      to_q, to_d;
  logic                      key_flag_q, key_flag_d;
  logic                      irq_blocked_q, irq_blocked_d;
  logic [17:0]               count_q, count_d;
  logic [DLY_W-1:0]          delay_q, delay_d;
  logic [7:0]                rdata_d;
  logic                      wake_d, take_d, dev_rst_d, pcsp_d;
  logic                      wake_q, take_q, dev_rst_q, pcsp_q;

  logic [4:0]  key;
  logic        key_ok;
  logic        overflow;
  logic        pin_fall;
  logic        irq_wake;
  logic [17:0] limit;
  logic [PORT_WIDTH-1:0] pin_fell;
  // raised by the clear instruction, a halt or a bad key
  logic        count_clear;

  assign key    = control_q[`WDW_KEY_MSB:`WDW_KEY_LSB];
  assign key_ok = (key == `WDW_KEY_A) || (key == `WDW_KEY_B); // [R11]

  // period select to terminal count
  always_comb begin
    case (control_q[`WDW_SEL_MSB:`WDW_SEL_LSB]) // [R9]
      3'h0:    limit = 18'h000ff;
      3'h1:    limit = 18'h003ff;
      3'h2:    limit = 18'h00fff;
      3'h3:    limit = 18'h03fff;
      3'h4:    limit = 18'h07fff;
      3'h5:    limit = 18'h0ffff;
      3'h6:    limit = 18'h1ffff;
      default: limit = 18'h3ffff; // [R10]
    endcase
  end

  // counter advances only on oscillator ticks
  assign overflow = low_speed_internal_osc && (count_q == limit); // [R8]
  // one edge detector per pin; idle level high so release gives no false edge
  for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_pin
    always_ff @(posedge clock) begin
      if (rst) begin
        pins_q[i] <= 1'b1;
      end else begin
        pins_q[i] <= pins_d[i];
      end
    end
    assign pin_fell[i] = pins_q[i] && !port_a_in[i] && wake_en_q[i]; // [R4]
  end
  assign pin_fall = |pin_fell;
  // a request already raised at halt is masked until it drops
  assign irq_wake = irq_request && !irq_blocked_q; // [R7]

  always_comb begin
    state_d       = state_q;
    control_d     = control_q;
    wake_en_d     = wake_en_q;
    pins_d        = port_a_in;
    pdf_d         = pdf_q;
    to_d          = to_q;
    key_flag_d    = key_flag_q;
    irq_blocked_d = irq_blocked_q && irq_request;
    count_clear   = 1'b0;
    delay_d       = delay_q;
    wake_d        = 1'b0;
    take_d        = 1'b0;
    dev_rst_d     = 1'b0;
    pcsp_d        = 1'b0;

    if (reg_write) begin
      case (reg_addr)
        `WDW_ADDR_CONTROL:     control_d = reg_wdata;
        // only a zero clears; a one written is ignored
        `WDW_ADDR_RESET_CAUSE: if (!reg_wdata[`WDW_KEY_FLAG_BIT]) key_flag_d = 1'b0; // [R13]
        `WDW_ADDR_WAKE_EN:     wake_en_d = reg_wdata[PORT_WIDTH-1:0]; // [R4]
        default: ;
      endcase
    end

    if (watchdog_clear_instruction) begin
      count_clear = 1'b1; // [R16]
      pdf_d   = 1'b0; // [R3]
      to_d    = 1'b0;
    end

    case (state_q)
      WDW_RUN: begin
        if (!key_ok) begin
          // bad key already in place: clear counter, wait out the delay
          count_clear = 1'b1; // [R16]
          delay_d = DLY_W'(SRESET_CYCLES);
          state_d = WDW_KEY_WAIT; // [R11]
        end else if (halt_exec) begin
          state_d       = WDW_HALTED;
          pdf_d         = 1'b1; // [R2]
          to_d          = 1'b0;
          count_clear   = 1'b1; // [R19]
          irq_blocked_d = irq_request; // [R7]
        end else if (overflow) begin
          to_d      = 1'b1; // [R14]
          dev_rst_d = 1'b1; // [R14]
        end
      end
      WDW_HALTED: begin
        if (overflow) begin
          to_d    = 1'b1; // [R15]
          pdf_d   = 1'b1; // [R15]
          pcsp_d  = 1'b1; // [R15]
          wake_d  = 1'b1; // [R1]
          state_d = WDW_RUN;
        end else if (pin_fall || irq_wake) begin
          wake_d  = 1'b1; // [R1]
          // pin wake or unserviceable interrupt resumes after the halt
          take_d  = irq_wake && irq_enabled && !stack_full; // [R5] [R6]
          state_d = WDW_RUN;
        end
      end
      WDW_KEY_WAIT: begin
        count_clear = 1'b1;
        if (delay_q <= DLY_W'(1)) begin
          // the reset restores the key, so the flag survives it
          key_flag_d = 1'b1; // [R13]
          dev_rst_d  = 1'b1; // [R11]
          control_d  = `WDW_CONTROL_RESET; // [R12]
          state_d    = WDW_RUN;
        end else begin
          delay_d = delay_q - DLY_W'(1);
        end
      end
      default: state_d = WDW_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      // power-on: key enabling, flags clear, counter from zero
      state_q       <= WDW_RUN;
      control_q     <= `WDW_CONTROL_RESET; // [R12]
      wake_en_q     <= '0;
      pdf_q         <= 1'b0; // [R3]
      to_q          <= 1'b0;
      key_flag_q    <= 1'b0;
      irq_blocked_q <= 1'b0;
      delay_q       <= '0;
    end else begin
      state_q       <= state_d;
      control_q     <= control_d;
      wake_en_q     <= wake_en_d;
      pdf_q         <= pdf_d;
      to_q          <= to_d;
      key_flag_q    <= key_flag_d;
      irq_blocked_q <= irq_blocked_d;
      delay_q       <= delay_d;
    end
  end

  // result pulses reset low so nothing fires as reset drops
  always_ff @(posedge clock) begin
    if (rst) begin
      wake_q        <= 1'b0;
      take_q        <= 1'b0;
      dev_rst_q     <= 1'b0;
      pcsp_q        <= 1'b0; // [R18]
    end else begin
      wake_q        <= wake_d;
      take_q        <= take_d;
      dev_rst_q     <= dev_rst_d;
      pcsp_q        <= pcsp_d;
    end
  end

  // counter group: any clear event wins over a tick in the same cycle
  always_comb begin
    count_d = count_q;
    if (low_speed_internal_osc) begin
      count_d = overflow ? 18'h00000 : count_q + 18'h00001; // [R8]
    end
    if (count_clear) begin
      count_d = 18'h00000; // [R16]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      // power-on clears the counter, which then starts counting
      count_q <= 18'h00000;
    end else begin
      count_q <= count_d;
    end
  end

  // read group: data stands only in the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        `WDW_ADDR_CONTROL:     rdata_d = control_q;
        `WDW_ADDR_RESET_CAUSE: rdata_d[`WDW_KEY_FLAG_BIT] = key_flag_q;
        `WDW_ADDR_STATUS: begin
          rdata_d[`WDW_PDF_BIT] = pdf_q;
          rdata_d[`WDW_TO_BIT]  = to_q;
        end
        `WDW_ADDR_WAKE_EN:     rdata_d[PORT_WIDTH-1:0] = wake_en_q;
        default:               rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  assign halted        = (state_q == WDW_HALTED);
  assign wake          = wake_q;
  assign wake_take_irq = take_q;
  // core treats this as full reset; program counter restarts at zero
  assign device_reset  = dev_rst_q; // [R18]
  assign pc_sp_reset   = pcsp_q;

endmodule // wdw_watchdog_wakeup

`default_nettype wire

// ===== verification/wdw_watchdog_wakeup_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module wdw_watchdog_wakeup_monitor (
  // observed ports
  input wire logic clock,
  input wire logic rst,
  input wire logic halt_exec,
  input wire logic irq_enabled,
  input wire logic stack_full,
  input wire logic halted,
  input wire logic wake,
  input wire logic wake_take_irq,
  input wire logic device_reset,
  input wire logic pc_sp_reset
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_wake_exit;
    wake && !halted;
  endsequence
  chk_halt_enter: assert property (halt_exec && !halted |=> halted)
    else $error("halt did not enter low power");
  chk_wake_exit: assert property ($fell(halted) |-> s_wake_exit)
    else $error("low power left without wake");
  chk_wake_pulse: assert property (wake |-> $past(halted) ##1 !wake)
    else $error("wake not a single pulse from halt");
  chk_irq_service: assert property (wake_take_irq |-> wake && $past(irq_enabled && !stack_full))
    else $error("interrupt serviced when it must not be");
  chk_halt_ovf: assert property (pc_sp_reset |-> wake && !device_reset)
    else $error("halted overflow gave wrong reset");
  chk_ovf_once: assert property (pc_sp_reset |=> !pc_sp_reset && !halted)
    else $error("halted overflow pulse too long");
  chk_full_reset: assert property (device_reset |-> !halted ##1 !device_reset)
    else $error("full reset while halted or too long");
  chk_no_stray: assert property (!halted |=> !wake)
    else $error("wake while running");
endmodule // wdw_watchdog_wakeup_monitor
bind wdw_watchdog_wakeup wdw_watchdog_wakeup_monitor u_mon (.clock(clock), .rst(rst),
  .halt_exec(halt_exec), .irq_enabled(irq_enabled), .stack_full(stack_full),
  .halted(halted), .wake(wake), .wake_take_irq(wake_take_irq),
  .device_reset(device_reset), .pc_sp_reset(pc_sp_reset));
`default_nettype wire

// ===== verification/testbench.sv
`include "wdw_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 0, rst = 1, osc = 0, halt_exec = 0, clr = 0, wr_s = 0, rd_s = 0;
  logic irq_request = 0, irq_enabled = 0, stack_full = 0;
  logic [7:0] port_a_in = 8'hff, wdat = 8'h00, rdat, v;
  logic [3:0] addr = 4'h0;
  logic halted, wake, wake_take_irq, device_reset, pc_sp_reset;
  integer seed = 32'h0cfa;
  int bad_count = 0, num_checks = 0, n_dr = 0, n_ps = 0, n_wk = 0, n_ti = 0, k;
  // short software reset delay keeps key tests quick
  wdw_watchdog_wakeup #(.SRESET_CYCLES(3)) u_wdw_watchdog_wakeup (.clock(clock), .rst(rst),
    .low_speed_internal_osc(osc), .halt_exec(halt_exec), .watchdog_clear_instruction(clr),
    .irq_request(irq_request), .irq_enabled(irq_enabled), .stack_full(stack_full),
    .port_a_in(port_a_in), .reg_addr(addr), .reg_wdata(wdat), .reg_write(wr_s),
    .reg_read(rd_s), .reg_rdata(rdat), .halted(halted), .wake(wake),
    .wake_take_irq(wake_take_irq), .device_reset(device_reset), .pc_sp_reset(pc_sp_reset));
  always #4 clock = ~clock;
  always @(posedge clock) begin
    n_dr <= n_dr + int'(device_reset);
    n_ps <= n_ps + int'(pc_sp_reset);
    n_wk <= n_wk + int'(wake);
    n_ti <= n_ti + int'(wake_take_irq);
  end
  function automatic int period(input int s);
    return 1 << (s < 4 ? 8 + 2 * s : 11 + s);
  endfunction
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    chk_val(got[7:0], exp[7:0]);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdat <= d;
    wr_s <= 1;
    @(posedge clock);
    wr_s <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd_s <= 1;
    @(posedge clock);
    rd_s <= 0;
    #1 chk_val(rdat, e);
  endtask
  task automatic strobe(input bit h);
    @(posedge clock);
    halt_exec <= h;
    clr <= !h;
    @(posedge clock);
    halt_exec <= 0;
    clr <= 0;
    cyc(2);
  endtask
  // oscillator held high: one tick per clock keeps long periods affordable
  task automatic ticks(input int n);
    @(posedge clock);
    osc <= 1;
    cyc(n);
    osc <= 0;
    cyc(3);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    cyc(100000);
    bad_count++;
    report_and_stop();
  end
  initial begin
    cyc(5);
    rst <= 0;
    rd(`WDW_ADDR_CONTROL, `WDW_CONTROL_RESET);
    rd(`WDW_ADDR_STATUS, 8'h00);
    for (int s = 0; s < 5; s++) begin
      v = {($random(seed) & 1) ? `WDW_KEY_B : `WDW_KEY_A, 3'(s)};
      wr(`WDW_ADDR_CONTROL, v);
      rd(`WDW_ADDR_CONTROL, v);
      strobe(0);
      ticks(period(s) - 1);
      chk_cnt(n_dr, s);
      ticks(1);
      chk_cnt(n_dr, s + 1);
      rd(`WDW_ADDR_STATUS, 8'h02);
    end
    $display("test periods done");
    wr(`WDW_ADDR_CONTROL, 8'h50);
    strobe(0);
    rd(`WDW_ADDR_STATUS, 8'h00);
    ticks(200);
    strobe(0);
    ticks(200);
    chk_cnt(n_dr, 5);
    k = $random(seed) & 7;
    wr(`WDW_ADDR_WAKE_EN, 8'h01 << k);
    strobe(1);
    chk_val({7'h0, halted}, 8'h01);
    rd(`WDW_ADDR_STATUS, 8'h01);
    port_a_in <= ~(8'h01 << ((k + 1) % 8));
    cyc(3);
    chk_cnt(n_wk, 0);
    port_a_in <= 8'h00;
    cyc(3);
    chk_cnt(n_wk, 1);
    port_a_in <= 8'hff;
    for (int i = 0; i < 4; i++) begin
      irq_enabled <= i[0];
      stack_full <= i[1];
      strobe(1);
      irq_request <= 1;
      cyc(3);
      irq_request <= 0;
      chk_cnt(n_wk, 2 + i);
      chk_cnt(n_ti, i >= 1);
    end
    irq_request <= 1;
    strobe(1);
    cyc(3);
    chk_cnt(n_wk, 5);
    port_a_in <= 8'h00;
    cyc(3);
    chk_cnt(n_wk, 6);
    port_a_in <= 8'hff;
    irq_request <= 0;
    $display("test wake done");
    strobe(1);
    ticks(255);
    chk_cnt(n_ps, 0);
    ticks(1);
    chk_cnt(n_ps, 1);
    rd(`WDW_ADDR_STATUS, 8'h03);
    strobe(0);
    rd(`WDW_ADDR_STATUS, 8'h00);
    v[4:0] = 5'($random(seed));
    if (v[4:0] == `WDW_KEY_A || v[4:0] == `WDW_KEY_B)
      v[0] = !v[0];
    wr(`WDW_ADDR_CONTROL, {v[4:0], 3'h0});
    cyc(8);
    chk_cnt(n_dr, 6);
    rd(`WDW_ADDR_CONTROL, `WDW_CONTROL_RESET);
    wr(`WDW_ADDR_RESET_CAUSE, 8'hff);
    rd(`WDW_ADDR_RESET_CAUSE, 8'h01);
    wr(`WDW_ADDR_RESET_CAUSE, 8'h00);
    rd(`WDW_ADDR_RESET_CAUSE, 8'h00);
    $display("test key done");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
